//--- rtc_core_cfg.svh
`ifndef RTC_CORE_CFG_SVH
`define RTC_CORE_CFG_SVH
// Function
// R1: All bytes read/write; registers C and D read-only; register A bit 7 read-only. Bytes past register D read zero and ignore writes here.
// R2: Freeze bit set stops time byte updates; host sets it before writing time.
// R3: Format bit one selects binary, zero BCD; every update uses that format.
// R4: Host rewrites date bytes after format change, hours after hour-mode change.
// R5: In 12-hour mode hours top bit marks afternoon; value runs 1 to 12.
// R6: Time bytes always accessible; advanced and alarm-checked once per second.
// R7: Bytes 0..9 hold seconds, alarms, hours, weekday, date, month, year.
// R8: Weekday 1..7, seconds and minutes 0..59, 24-hour hours 0..23.
// R9: Register B bits 6,5,4 enable periodic, alarm, update-done interrupts.
// R10: Enabling a source whose flag is already set asserts interrupt at once.
// R11: Host should read register C before enabling sources to drop stale flags.
// R12: Events set flags in register C regardless of enables.
// R13: Reading register C clears all flags and the summary bit.
// R14: Register C stays stable during a read; new events posted after it.
// R15: Interrupt held low while any flag and its enable are set; C bit 7 mirrors it.
// R16: Periodic rate chosen by register A rate bits, 500 ms to 122 us.
// R17: Alarm fires when hours, minutes and seconds all match their alarm bytes.
// R18: Alarm byte with top two bits set matches any value.
// R19: Wildcards give hourly, per-minute or per-second alarms.
// R20: Update-done flag set each update; interrupt only if enabled and not frozen.
// R21: Oscillator off after reset; no timekeeping until software starts it.
// R22: Register A bits 6..4: 010 runs, 11x holds divider reset, others stop.
// R23: Reset clears enables, square-out enable, all flags, and releases interrupt.
// R24: Update-pending bit rises 244 us before each update; freeze bit clears it.
// R25: First update comes 500 ms after writing run pattern.
// R26: Setting the freeze bit clears the update-done interrupt enable.
// R27: Carries through date, month lengths, leap February, year; weekday daily.
// R28: Second tick and periodic rates come from a binary chain off 32768 Hz.
`define SYS_CLK_HZ 100000000
`define OSC_CLK_HZ 32768
`define PHASE_W 27
`define BUC_US 244
`define NUM_TIME 10
`define ADDR_SEC 4'h0
`define ADDR_SEC_AL 4'h1
`define ADDR_MIN 4'h2
`define ADDR_MIN_AL 4'h3
`define ADDR_HR 4'h4
`define ADDR_HR_AL 4'h5
`define ADDR_WDAY 4'h6
`define ADDR_MDAY 4'h7
`define ADDR_MON 4'h8
`define ADDR_YEAR 4'h9
`define ADDR_A 8'h0A
`define ADDR_B 8'h0B
`define ADDR_C 8'h0C
`define ADDR_D 8'h0D
`define B_SET 7
`define B_PIE 6
`define B_AIE 5
`define B_UIE 4
`define B_SQUARE_OUT_ENABLE 3
`define B_DM 2
`define B_HR24 1
`define PM_BIT 7
`define OSC_RUN 3'h2
`define OSC_HOLD 2'h3
`define DIV_HALF 15'h4000
`define DIV_LAST 15'h7FFF
`define DIV_SPAN 32768
`define DONT_CARE 2'h3
`define SEC_LIM 8'h3C
`define MIN_LIM 8'h3C
`define HR_LIM 8'h18
`define WDAY_LIM 8'h07
`define MON_LIM 8'h0C
`define YEAR_LIM 8'h64
`define NOON 8'h0C
`define TEN 8'h0A
`define FEB 8'h02
`define REG_D_VAL 8'h00
`endif

//--- rtc_types_pkg.sv
`include "rtc_core_cfg.svh"
package rtc_types_pkg;
  typedef struct packed {
    logic [2:0]                as_p;
    logic [2:0]                ds_n_p;
    logic [2:0]                rw_n_p;
    logic [2:0]                ce_n_p;
    logic [1:0][7:0]           ad_p;
    logic [7:0]                addr;
    logic [`NUM_TIME-1:0][7:0] tb;
    logic [2:0]                osc;
    logic [3:0]                rs;
    logic                      update_pending_flag;
    logic [7:0]                ctl_b;
    logic [2:0]                flags;
    logic [2:0]                pend;
    logic [14:0]               div;
    logic [`PHASE_W-1:0]       phase;
    logic [7:0]                ad_out;
    logic                      ad_oe_n;
    logic                      irq_level;
    logic                      irq_oe_n;
  } state_type;
endpackage

//--- rtc_core.sv
`timescale 1ns/1ps
`include "rtc_core_cfg.svh"
module rtc_core #(
  parameter int SYS_HZ = `SYS_CLK_HZ,
  parameter int OSC_HZ = `OSC_CLK_HZ
) (
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] ad_in,
  output logic      [7:0] ad_out,
  output logic            ad_oe_n_out,
  input  wire logic       as_in,
  input  wire logic       ds_n_in,
  input  wire logic       rw_n_in,
  input  wire logic       ce_n_in,
  output logic            irq_out,
  output logic            irq_oe_n_out
);
  localparam logic [`PHASE_W-1:0] PH_INC = `PHASE_W'(OSC_HZ);
  localparam logic [`PHASE_W-1:0] PH_MOD = `PHASE_W'(SYS_HZ);
  localparam int LEAD = (`BUC_US * OSC_HZ + 999999) / 1000000;
  localparam logic [14:0] UIP_FROM = 15'(`DIV_SPAN - LEAD);

  rtc_types_pkg::state_type q;
  rtc_types_pkg::state_type n;
  logic       wr_end;
  logic       rd_on;
  logic       rd_end;
  logic       c_sel;
  logic       sec_tick;
  logic [2:0] ev;

  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    return bin ? v : 8'(v[7:4] * `TEN) + {4'h0, v[3:0]};
  endfunction

  function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
    logic [7:0] t;
    logic [7:0] u;
    t = v / `TEN;
    u = v % `TEN;
    return bin ? v : {t[3:0], u[3:0]};
  endfunction

  function automatic logic [7:0] hr_to24(input logic [7:0] h, input logic bin,
                                         input logic h24);
    logic [7:0] x;
    x = to_bin({1'b0, h[6:0]}, bin);
    if (h24) begin
      return to_bin(h, bin);
    end
    return (x == `NOON ? 8'h00 : x) + (h[`PM_BIT] ? `NOON : 8'h00); // R5
  endfunction

  function automatic logic [7:0] hr_from24(input logic [7:0] x, input logic bin,
                                           input logic h24);
    logic [7:0] y;
    if (h24) begin
      return from_bin(x, bin);
    end
    y = (x >= `NOON) ? x - `NOON : x;
    if (y == 8'h00) begin
      y = `NOON;
    end
    y = from_bin(y, bin);
    return {x >= `NOON, y[6:0]}; // R5
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    case (m)
      `FEB:                       return (y[1:0] == 2'h0) ? 8'h1D : 8'h1C; // R27
      8'h04, 8'h06, 8'h09, 8'h0B: return 8'h1E;
      default:                    return 8'h1F;
    endcase
  endfunction

  function automatic logic alarm_hit(input logic [7:0] al, input logic [7:0] t);
    return (al[7:6] == `DONT_CARE) || (al == t); // R18
  endfunction

  function automatic logic [14:0] tap_mask(input logic [3:0] rs);
    case (rs)
      4'h0:    return 15'h0000;
      4'h1:    return 15'h007F;
      4'h2:    return 15'h00FF;
      default: return 15'((16'h0001 << (rs - 4'h1)) - 16'h0001); // R16
    endcase
  endfunction

  function automatic logic [2:0] int_en(input logic [7:0] b);
    return {b[`B_PIE], b[`B_AIE], b[`B_UIE] & ~b[`B_SET]}; // R9 R20
  endfunction

  always_comb begin
    logic       bin;
    logic       h24;
    logic       tick;
    logic       per_ev;
    logic       al_ev;
    logic       carry;
    logic [7:0] v;
    logic [7:0] wd;
    logic [7:0] rdata;
    logic [14:0] dnext;
    bin    = q.ctl_b[`B_DM];
    h24    = q.ctl_b[`B_HR24];
    tick   = 1'b0;
    per_ev = 1'b0;
    al_ev  = 1'b0;
    carry  = 1'b0;
    v      = 8'h00;
    wd     = q.ad_p[1];
    rdata  = 8'h00;
    dnext  = q.div + 15'h0001;
    n = q;
    n.as_p   = {q.as_p[1:0], as_in};
    n.ds_n_p = {q.ds_n_p[1:0], ds_n_in};
    n.rw_n_p = {q.rw_n_p[1:0], rw_n_in};
    n.ce_n_p = {q.ce_n_p[1:0], ce_n_in};
    n.ad_p   = {q.ad_p[0], ad_in};
    if (q.as_p[2] && !q.as_p[1]) begin
      n.addr = q.ad_p[1];
    end
    wr_end = !q.ce_n_p[1] && !q.rw_n_p[2] && q.rw_n_p[1];
    rd_on  = !q.ce_n_p[1] && !q.ds_n_p[1];
    rd_end = !q.ce_n_p[1] && !q.ds_n_p[2] && q.ds_n_p[1];
    c_sel  = q.addr == `ADDR_C;
    // oscillator phase and divider chain
    sec_tick = 1'b0;
    if (q.osc == `OSC_RUN || q.osc[2:1] == `OSC_HOLD) begin
      n.phase = q.phase + PH_INC;
      if (n.phase >= PH_MOD) begin
        n.phase = n.phase - PH_MOD;
        tick = 1'b1;
      end
    end
    if (q.osc[2:1] == `OSC_HOLD) begin
      n.div = 15'h0000; // R22
    end else if (q.osc == `OSC_RUN && tick) begin
      n.div    = dnext; // R28
      sec_tick = q.div == `DIV_LAST;
      per_ev   = (q.rs != 4'h0) && ((dnext & tap_mask(q.rs)) == 15'h0000); // R16
    end
    n.update_pending_flag = (q.osc == `OSC_RUN) && (q.div >= UIP_FROM) && !q.ctl_b[`B_SET]; // R24
    // once-per-second update
    if (sec_tick && !q.ctl_b[`B_SET]) begin // R2 R6
      v = to_bin(q.tb[`ADDR_SEC], bin) + 8'h01;
      carry = v == `SEC_LIM;
      n.tb[`ADDR_SEC] = from_bin(carry ? 8'h00 : v, bin); // R3 R8
      if (carry) begin
        v = to_bin(q.tb[`ADDR_MIN], bin) + 8'h01;
        carry = v == `MIN_LIM;
        n.tb[`ADDR_MIN] = from_bin(carry ? 8'h00 : v, bin); // R27
      end
      if (carry) begin
        v = hr_to24(q.tb[`ADDR_HR], bin, h24) + 8'h01;
        carry = v == `HR_LIM;
        n.tb[`ADDR_HR] = hr_from24(carry ? 8'h00 : v, bin, h24); // R5 R8
      end
      if (carry) begin
        v = to_bin(q.tb[`ADDR_WDAY], bin);
        n.tb[`ADDR_WDAY] = from_bin(v >= `WDAY_LIM ? 8'h01 : v + 8'h01, bin); // R8
        v = to_bin(q.tb[`ADDR_MDAY], bin);
        carry = v >= month_days(to_bin(q.tb[`ADDR_MON], bin),
                                to_bin(q.tb[`ADDR_YEAR], bin));
        n.tb[`ADDR_MDAY] = from_bin(carry ? 8'h01 : v + 8'h01, bin); // R27
      end
      if (carry) begin
        v = to_bin(q.tb[`ADDR_MON], bin);
        carry = v >= `MON_LIM;
        n.tb[`ADDR_MON] = from_bin(carry ? 8'h01 : v + 8'h01, bin);
      end
      if (carry) begin
        v = to_bin(q.tb[`ADDR_YEAR], bin) + 8'h01;
        n.tb[`ADDR_YEAR] = from_bin(v == `YEAR_LIM ? 8'h00 : v, bin); // R7
      end
    end
    if (sec_tick) begin
      al_ev = alarm_hit(q.tb[`ADDR_SEC_AL], n.tb[`ADDR_SEC])
           && alarm_hit(q.tb[`ADDR_MIN_AL], n.tb[`ADDR_MIN])
           && alarm_hit(q.tb[`ADDR_HR_AL], n.tb[`ADDR_HR]); // R17 R19
    end
    ev = {per_ev, al_ev, sec_tick}; // R20
    // host writes win over the update in the same cycle
    if (wr_end) begin // R1
      if (q.addr < 8'(`NUM_TIME)) begin
        n.tb[q.addr[3:0]] = wd;
      end else if (q.addr == `ADDR_A) begin
        n.osc = wd[6:4];
        n.rs  = wd[3:0];
        if (wd[6:4] == `OSC_RUN && q.osc != `OSC_RUN) begin
          n.div = `DIV_HALF; // R25
        end
      end else if (q.addr == `ADDR_B) begin
        n.ctl_b = wd;
        if (wd[`B_SET]) begin
          n.ctl_b[`B_UIE] = 1'b0; // R26
          n.update_pending_flag = 1'b0; // R24
        end
      end
    end
    // status flags with read-to-clear and hold during a read
    if (rd_end && c_sel) begin
      n.flags = q.pend | ev; // R13 R14
      n.pend  = 3'h0;
    end else if (rd_on && c_sel) begin
      n.pend = q.pend | ev; // R14
    end else begin
      n.flags = q.flags | ev; // R12
    end
    n.irq_level = 1'b0;
    n.irq_oe_n  = ~|(n.flags & int_en(n.ctl_b)); // R10 R15
    if (q.addr < 8'(`NUM_TIME)) begin
      rdata = q.tb[q.addr[3:0]];
    end else begin
      case (q.addr)
        `ADDR_A: rdata = {q.update_pending_flag, q.osc, q.rs};
        `ADDR_B: rdata = q.ctl_b;
        `ADDR_C: rdata = {~q.irq_oe_n, q.flags, 4'h0}; // R15
        `ADDR_D: rdata = `REG_D_VAL;
        default: rdata = 8'h00;
      endcase
    end
    n.ad_out  = rdata;
    n.ad_oe_n = ~rd_on;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0; // R21 R23
      q.as_p     <= 3'h0;
      q.ds_n_p   <= 3'h7;
      q.rw_n_p   <= 3'h7;
      q.ce_n_p   <= 3'h7;
      q.ad_oe_n  <= 1'b1;
      q.irq_oe_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign ad_out       = q.ad_out;
  assign ad_oe_n_out  = q.ad_oe_n;
  assign irq_out      = q.irq_level;
  assign irq_oe_n_out = q.irq_oe_n;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence seq_c_reading;
    rd_on && c_sel;
  endsequence
  sequence seq_start_write;
    wr_end && q.addr == `ADDR_A && q.ad_p[1][6:4] == `OSC_RUN && q.osc != `OSC_RUN;
  endsequence

  AST_IRQ_FOLLOWS: assert property ( // R15
    irq_oe_n_out == ~|(q.flags & int_en(q.ctl_b)))
    else $error("interrupt pin disagrees with flags and enables");
  AST_ANY_INTERRUPT_FLAG_READ: assert property ( // R15
    seq_c_reading |=> ad_out[7] == $past(~irq_oe_n_out))
    else $error("summary bit does not mirror interrupt pin");
  AST_C_CLEAR: assert property ( // R13
    rd_end && c_sel && q.pend == 3'h0 && ev == 3'h0 |=> q.flags == 3'h0 && irq_oe_n_out)
    else $error("reading status did not clear flags");
  AST_C_STABLE: assert property ( // R14
    seq_c_reading ##1 seq_c_reading |-> $stable(q.flags))
    else $error("status changed during a read");
  AST_NO_ENABLE: assert property ( // R9
    n.ctl_b[6:4] == 3'h0 |=> irq_oe_n_out)
    else $error("interrupt asserted with all sources disabled");
  AST_FREEZE: assert property ( // R2
    q.ctl_b[`B_SET] && !wr_end |=> $stable(q.tb))
    else $error("time bytes moved while frozen");
  AST_UPDATE_FLAG: assert property ( // R20
    sec_tick |=> q.flags[0] || q.pend[0])
    else $error("update-done flag not raised");
  AST_SET_UIE: assert property ( // R26
    q.ctl_b[`B_SET] |-> !q.ctl_b[`B_UIE])
    else $error("update-done enable survived freeze");
  AST_HOLD_CHAIN: assert property ( // R22
    q.osc[2:1] == `OSC_HOLD && !wr_end |=> q.div == 15'h0000)
    else $error("divider not held in reset");
  AST_OSC_STOP: assert property ( // R22
    q.osc != `OSC_RUN && q.osc[2:1] != `OSC_HOLD && !wr_end |=> $stable(q.div))
    else $error("divider moved with oscillator off");
  AST_FIRST_UPDATE: assert property ( // R25
    seq_start_write |=> q.div == `DIV_HALF)
    else $error("start pattern did not preload half second");
  AST_UIP_CLEAR: assert property ( // R24
    q.ctl_b[`B_SET] |=> !q.update_pending_flag)
    else $error("update-pending bit set while frozen");
endmodule

//--- host_bus.sv
`timescale 1ns/1ps
module host_bus (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_ad_in,
  input  wire logic       dev_oe_n_in,
  output logic      [7:0] ad_out,
  output logic            as_out,
  output logic            ds_n_out,
  output logic            rw_n_out,
  output logic            ce_n_out
);
  logic       drive = 1'b0;
  logic [7:0] val = 8'h00;
  logic [7:0] last = 8'h00;
  // released bus: inverse of last level
  assign ad_out = drive ? val : (!dev_oe_n_in ? dev_ad_in : ~last);
  always @(posedge clk_in) last <= ad_out;
  initial begin
    as_out = 1'b0;
    ds_n_out = 1'b1;
    rw_n_out = 1'b1;
    ce_n_out = 1'b1;
  end
  task automatic addr(input logic [7:0] a);
    @(negedge clk_in);
    ce_n_out = 1'b0;
    drive = 1'b1;
    val = a;
    as_out = 1'b1;
    repeat (3) @(negedge clk_in);
    as_out = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr(a);
    val = d;
    rw_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    rw_n_out = 1'b1;
    repeat (2) @(negedge clk_in);
    drive = 1'b0;
    ce_n_out = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    addr(a);
    drive = 1'b0;
    ds_n_out = 1'b0;
    n = 0;
    while (dev_oe_n_in !== 1'b0 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    d = (dev_oe_n_in === 1'b0) ? dev_ad_in : 8'hXX;
    ds_n_out = 1'b1;
    repeat (6) @(negedge clk_in);
    ce_n_out = 1'b1;
  endtask
endmodule

//--- tb_rtc_calendar_alarm_interrupts.sv
`timescale 1ns/1ps
module tb_rtc_calendar_alarm_interrupts;
  typedef logic [7:0] list_type [10];
  logic       sys_clk_in;
  logic       resetn_in = 1'b0;
  logic [7:0] ad_pin, dev_ad, rv;
  logic       dev_oe_n, as_s, ds_n, rw_n, ce_n, irq_d, irq_oe_n;
  int         miscompares, comparisons, cyc, upd, n;
  // open drain with pull-up
  wire        irq_n = irq_oe_n ? 1'b1 : irq_d;

  rtc_core #(.SYS_HZ(32768), .OSC_HZ(32768)) dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .ad_in(ad_pin),
    .ad_out(dev_ad), .ad_oe_n_out(dev_oe_n), .as_in(as_s), .ds_n_in(ds_n),
    .rw_n_in(rw_n), .ce_n_in(ce_n), .irq_out(irq_d), .irq_oe_n_out(irq_oe_n));
  host_bus host (
    .clk_in(sys_clk_in), .dev_ad_in(dev_ad), .dev_oe_n_in(dev_oe_n), .ad_out(ad_pin),
    .as_out(as_s), .ds_n_out(ds_n), .rw_n_out(rw_n), .ce_n_out(ce_n));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    check($sformatf("byte %h", a), rv, exp);
  endtask
  task automatic irqchk(input logic lvl);
    check("irq pin", {7'h0, irq_n}, {7'h0, lvl});
  endtask
  task automatic set_time(input list_type v);
    for (int i = 0; i < 10; i++) host.wr(8'(i), v[i]);
  endtask
  task automatic time_chk(input list_type e);
    for (int i = 0; i < 10; i++) rdchk(8'(i), e[i]);
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq_n !== 1'b0 && n < lim) begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask

  task automatic t_reset();
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0C, 8'h00);
    rdchk(8'h0D, 8'h00);
    irqchk(1'b1);
    host.wr(8'h0C, 8'hFF);
    rdchk(8'h0C, 8'h00);
    host.wr(8'h0A, 8'hE6);
    rdchk(8'h0A, 8'h66);
    rdchk(8'h0E, 8'h00);
  endtask
  task automatic t_map();
    for (int i = 0; i < 10; i++) host.wr(8'(i), 8'(8'h41 + i));
    for (int i = 0; i < 10; i++) rdchk(8'(i), 8'(8'h41 + i));
  endtask
  task automatic t_rollover();
    host.wr(8'h0B, 8'h86);
    set_time('{8'h3B, 8'hC0, 8'h3B, 8'hC0, 8'h17, 8'hC0, 8'h07, 8'h1F, 8'h0C, 8'h63});
    host.wr(8'h0B, 8'h26);
    host.rd(8'h0C, rv);
    upd = cyc;
    host.wr(8'h0A, 8'h20);
    wait_irq(17000);
    check("first update", 8'(cyc - upd >= 16384 && cyc - upd <= 16430), 8'h01);
    upd = cyc;
    rdchk(8'h0C, 8'hB0);
    irqchk(1'b1);
    time_chk('{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00});
  endtask
  task automatic t_periodic();
    host.wr(8'h0A, 8'h23);
    repeat (40) @(negedge sys_clk_in);
    irqchk(1'b1);
    host.wr(8'h0B, 8'h46);
    irqchk(1'b0);
    host.rd(8'h0C, rv);
    wait_irq(20);
    check("periodic gap", 8'(n <= 6), 8'h01);
    host.wr(8'h0A, 8'h20);
    rdchk(8'h0C, 8'hC0);
    rdchk(8'h0C, 8'h00);
    irqchk(1'b1);
  endtask
  task automatic t_bcd12();
    host.wr(8'h0B, 8'h80);
    set_time('{8'h59, 8'hC0, 8'h59, 8'hC0, 8'h91, 8'hC0, 8'h03, 8'h28, 8'h02, 8'h04});
    host.wr(8'h0B, 8'h10);
    host.rd(8'h0C, rv);
    wait_irq(33000);
    check("second tick", 8'(cyc - upd >= 32760 && cyc - upd <= 32776), 8'h01);
    upd = cyc;
    rdchk(8'h0C, 8'hB0);
    time_chk('{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h12, 8'hC0, 8'h04, 8'h29, 8'h02, 8'h04});
  endtask
  task automatic t_freeze();
    host.wr(8'h0B, 8'h90);
    rdchk(8'h0B, 8'h80);
    while (cyc < upd + 32832) @(negedge sys_clk_in);
    irqchk(1'b1);
    rdchk(8'h0C, 8'h30);
    rdchk(8'h00, 8'h00);
    rdchk(8'h0A, 8'h20);
  endtask

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    t_reset();
    t_map();
    t_rollover();
    t_periodic();
    t_bcd12();
    t_freeze();
    test_done();
  end
endmodule
